/* peripheral_irq_flag_enable_bank.sv */
`timescale 1ns/100ps

// Summary of operation
// - Oscillator failure sets flags_two bit 7; held until software clears.
// - Comparator input change sets flags_two bit 6; held until written zero.
// - Network module event sets flags_two bit 5; source in module's own reg.
// - Collisions set flags_two bit 3 and flags_three bit 6; software clears.
// - Bit 2 of flags_two and enables_two reads zero, writes ignored.
// - Timer three overflow sets flags_two bit 1 until cleared.
// - Capture or compare sets flags_two bit 0; unused in PWM mode.
// - Capcmp five, four, three set bits 2..0 of flags_three; not in PWM.
// - Sync port two completion sets flags_three bit 7; software clears.
// - Flags_three bit 5 read-only, mirrors serial two receive buffer full.
// - Flags_three bit 4 read-only, mirrors serial two transmit buffer empty.
// - Timer four period match sets flags_three bit 3 until cleared.
// - Sync port two bits only at 100 pins; serial two at 80 or 100.
// - Without priority scheme, no request passes unless global enable set.
// - Enables_one holds one enable per source, bit 7 down to bit 0.
// - Parallel port enable exists at 100 pins in microcontroller mode only.
// - Enables_two mirrors flags_two layout; one enables the source.
// - Enables_three mirrors flags_three layout; one enables the source.
// - Flags set on their condition regardless of any enable bit.
// - Priority enable bit one selects two levels; zero single level.
module peripheral_irq_flag_enable_bank #(
   parameter int PIN_COUNT = 100
) (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire irq_bank_pkg::avs_req_t   avs_req,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   input  wire irq_bank_pkg::irq_events_t evt,
   input  wire logic [3:0]               capcmp_pwm_mode,
   input  wire logic                     serial_two_rx_full,
   input  wire logic                     serial_two_tx_empty,
   input  wire logic [7:0]               periph_flags_one,
   input  wire logic                     micro_mode,
   output logic                          periph_irq,
   output logic                          priority_scheme_en,
   output logic                          peripheral_global_irq_en
);
   import irq_bank_pkg::*;

   // ---------------------------------------------------------
   // Variant masks
   // ---------------------------------------------------------
   // Bits absent on a smaller variant read zero and never set.
   localparam logic [7:0] THR_VARIANT =
      ((PIN_COUNT >= PINS_SYNC_TWO) ? SYNC_TWO_BITS : 8'h00) |
      ((PIN_COUNT >= PINS_SER_TWO)  ? SER_TWO_BITS  : 8'h00) |
      ~(SYNC_TWO_BITS | SER_TWO_BITS);
   localparam logic PAR_VARIANT = (PIN_COUNT >= PINS_PARALLEL);

   typedef struct packed {
      logic [7:0]  flags_two;
      logic [7:0]  flags_thr;
      logic [7:0]  en_one;
      logic [7:0]  en_two;
      logic [7:0]  en_thr;
      logic [7:0]  control;
      logic        ack;
      logic [31:0] rdata;
   } state_t;

   state_t     st_ff;
   state_t     nxt_st;
   logic [1:0] rst_sync_ff;
   logic       rst_n;
   logic [7:0] evt_two;
   logic [7:0] evt_thr;
   logic [7:0] flags_thr_view;
   logic [7:0] en_one_mask;
   logic [7:0] pend;
   logic       req;
   logic       wr_take;
   logic       wr_lane;

   // ---------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ---------------------------------------------------------
   // Event mapping
   // ---------------------------------------------------------
   always_comb begin
      evt_two = {evt.osc_fail,
                 evt.comparator_change,
                 evt.network_module,
                 1'b0,
                 evt.collision_one,
                 1'b0,
                 evt.timer_three_overflow,
                 evt.capcmp_two & ~capcmp_pwm_mode[0]};
      evt_thr = {evt.sync_port_two,
                 evt.collision_two,
                 2'b00,
                 evt.timer_four_match,
                 evt.capcmp_five & ~capcmp_pwm_mode[3],
                 evt.capcmp_four & ~capcmp_pwm_mode[2],
                 evt.capcmp_three & ~capcmp_pwm_mode[1]};
      evt_thr = evt_thr & THR_VARIANT;
   end

   // Read-only buffer status lives in the serial port itself.
   assign flags_thr_view = ((st_ff.flags_thr & THR_SW_BITS) |
                            ({2'b00, serial_two_rx_full,
                              serial_two_tx_empty, 4'h0}))
                           & THR_VARIANT;

   // Parallel port enable only counts in microcontroller mode.
   assign en_one_mask = (PAR_VARIANT && micro_mode) ?
                        8'hFF : ~PARALLEL_BIT;

   // ---------------------------------------------------------
   // Avalon-MM slave: one wait state on every access
   // ---------------------------------------------------------
   assign req             = avs_req.read | avs_req.write;
   assign avs_waitrequest = req & ~st_ff.ack;
   assign wr_take         = avs_req.write & st_ff.ack;
   assign wr_lane         = wr_take & avs_req.byteenable[0];

   always_comb begin
      nxt_st     = st_ff;
      nxt_st.ack = req & ~st_ff.ack;

      // Set wins over a clear in the same cycle.
      nxt_st.flags_two = st_ff.flags_two | evt_two;
      nxt_st.flags_thr = (st_ff.flags_thr | evt_thr)
                         & THR_SW_BITS;

      if (wr_lane) begin
         unique case (avs_req.address)
            OFS_FLAGS_TWO: nxt_st.flags_two =
               (avs_req.writedata[7:0] & TWO_IMPL) | evt_two;
            OFS_FLAGS_THR: nxt_st.flags_thr =
               ((avs_req.writedata[7:0] & THR_VARIANT) | evt_thr)
               & THR_SW_BITS;
            OFS_EN_ONE: nxt_st.en_one =
               avs_req.writedata[7:0] & en_one_mask;
            OFS_EN_TWO: nxt_st.en_two =
               avs_req.writedata[7:0] & TWO_IMPL;
            OFS_EN_THR: nxt_st.en_thr =
               avs_req.writedata[7:0] & THR_VARIANT;
            OFS_CONTROL: nxt_st.control =
               avs_req.writedata[7:0] & CTRL_MASK;
            default: ;
         endcase
      end

      // Read data is staged during the wait state.
      nxt_st.rdata = 32'h0000_0000;
      if (avs_req.read && !st_ff.ack) begin
         unique case (avs_req.address)
            OFS_FLAGS_TWO: nxt_st.rdata[7:0] = st_ff.flags_two;
            OFS_FLAGS_THR: nxt_st.rdata[7:0] = flags_thr_view;
            OFS_EN_ONE:    nxt_st.rdata[7:0] = st_ff.en_one;
            OFS_EN_TWO:    nxt_st.rdata[7:0] = st_ff.en_two;
            OFS_EN_THR:    nxt_st.rdata[7:0] = st_ff.en_thr;
            OFS_CONTROL:   nxt_st.rdata[7:0] = st_ff.control;
            default:       nxt_st.rdata = 32'h0000_0000;
         endcase
      end else if (st_ff.ack) begin
         nxt_st.rdata = st_ff.rdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '{flags_two: REG_RESET, flags_thr: REG_RESET,
                    en_one: REG_RESET, en_two: REG_RESET,
                    en_thr: REG_RESET, control: REG_RESET,
                    ack: 1'b0, rdata: 32'h0000_0000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------
   // Request to the core
   // ---------------------------------------------------------
   assign priority_scheme_en       = st_ff.control[CTRL_PRIO_BIT];
   assign peripheral_global_irq_en = st_ff.control[CTRL_GLOB_BIT];
   assign avs_readdata             = st_ff.rdata;

   // Enables gate only the request, never the flags.
   assign pend = (periph_flags_one & st_ff.en_one & en_one_mask) |
                 (st_ff.flags_two & st_ff.en_two & TWO_IMPL) |
                 (flags_thr_view & st_ff.en_thr);

   // In priority mode the level selection sits downstream.
   assign periph_irq = (|pend) &
                       (priority_scheme_en |
                        peripheral_global_irq_en);

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_access_start;
      req && !st_ff.ack;
   endsequence

   sequence s_access_done;
      !avs_waitrequest;
   endsequence

   a_bus_one_wait: assert property (
      s_access_start |=> s_access_done)
      else $error("access not answered after one wait");

   a_osc_fail_set: assert property (
      evt.osc_fail |=> st_ff.flags_two[7])
      else $error("osc fail flag not set");

   a_cmp_flag_hold: assert property (
      st_ff.flags_two[6] && !wr_lane |=>
      st_ff.flags_two[6])
      else $error("comparator flag lost");

   a_net_flag_set: assert property (
      evt.network_module |=> st_ff.flags_two[5])
      else $error("network flag not set");

   a_coll_set_win: assert property (
      evt.collision_one && wr_lane |=>
      st_ff.flags_two[3])
      else $error("collision set lost to clear");

   a_unimpl_zero: assert property (
      !st_ff.flags_two[2] && !st_ff.en_two[2])
      else $error("unimplemented bit set");

   a_t3_flag_set: assert property (
      evt.timer_three_overflow |=>
      st_ff.flags_two[1])
      else $error("timer three flag not set");

   a_pwm_no_set: assert property (
      !st_ff.flags_two[0] && !wr_lane &&
      capcmp_pwm_mode[0] |=> !st_ff.flags_two[0])
      else $error("capture flag set in pwm mode");

   a_capcmp3_set: assert property (
      evt.capcmp_three && !capcmp_pwm_mode[1] |=>
      st_ff.flags_thr[0])
      else $error("capcmp three flag not set");

   a_rx_mirror: assert property (
      flags_thr_view[5] ==
      (serial_two_rx_full && PIN_COUNT >= PINS_SER_TWO))
      else $error("rx full view wrong");

   a_t4_flag_set: assert property (
      evt.timer_four_match |=> st_ff.flags_thr[3])
      else $error("timer four flag not set");

   a_irq_gated: assert property (
      !priority_scheme_en && !peripheral_global_irq_en
      |-> !periph_irq)
      else $error("request passed without global enable");

   a_irq_raised: assert property (
      (st_ff.flags_two[7] && st_ff.en_two[7] &&
       peripheral_global_irq_en) |-> periph_irq)
      else $error("request missing");

   a_wr_enable: assert property (
      wr_lane && avs_req.address == OFS_EN_TWO |=>
      st_ff.en_two == ($past(avs_req.writedata[7:0]) & TWO_IMPL))
      else $error("enable write not stored");

   // ---------------------------------------------------------
   // Further flag, enable and request checks
   // ---------------------------------------------------------
   // Each event source must land in its own bit one edge later.
   a_cmp_flag_set: assert property (
      evt.comparator_change |=> st_ff.flags_two[6])
      else $error("comparator flag not set");

   a_osc_flag_hold: assert property (
      st_ff.flags_two[7] && !wr_lane |=> st_ff.flags_two[7])
      else $error("osc fail flag lost");

   a_net_flag_hold: assert property (
      st_ff.flags_two[5] && !wr_lane |=> st_ff.flags_two[5])
      else $error("network flag lost");

   a_t4_flag_hold: assert property (
      st_ff.flags_thr[3] && !wr_lane |=> st_ff.flags_thr[3])
      else $error("timer four flag lost");

   a_capcmp2_set: assert property (
      evt.capcmp_two && !capcmp_pwm_mode[0] |=> st_ff.flags_two[0])
      else $error("capcmp two flag not set");

   a_capcmp4_set: assert property (
      evt.capcmp_four && !capcmp_pwm_mode[2] |=> st_ff.flags_thr[1])
      else $error("capcmp four flag not set");

   a_capcmp5_set: assert property (
      evt.capcmp_five && !capcmp_pwm_mode[3] |=> st_ff.flags_thr[2])
      else $error("capcmp five flag not set");

   a_coll_two_set: assert property (
      evt.collision_two && PIN_COUNT >= PINS_SYNC_TWO |=>
      st_ff.flags_thr[6])
      else $error("collision two flag not set");

   a_sync_two_set: assert property (
      evt.sync_port_two && PIN_COUNT >= PINS_SYNC_TWO |=>
      st_ff.flags_thr[7])
      else $error("sync port two flag not set");

   a_tx_mirror: assert property (
      flags_thr_view[4] ==
      (serial_two_tx_empty && PIN_COUNT >= PINS_SER_TWO))
      else $error("tx empty view wrong");

   // Absent bits must stay clear whatever software writes.
   a_small_no_sync: assert property (
      PIN_COUNT < PINS_SYNC_TWO |->
      st_ff.flags_thr[7:6] == 2'b00 && st_ff.en_thr[7:6] == 2'b00)
      else $error("absent sync port bits set");

   a_par_en_gone: assert property (
      wr_lane && avs_req.address == OFS_EN_ONE &&
      !(PAR_VARIANT && micro_mode) |=> !st_ff.en_one[7])
      else $error("parallel enable stored");

   a_en_one_write: assert property (
      wr_lane && avs_req.address == OFS_EN_ONE |=>
      st_ff.en_one ==
      ($past(avs_req.writedata[7:0]) & $past(en_one_mask)))
      else $error("enable one write not stored");

   a_en_thr_write: assert property (
      wr_lane && avs_req.address == OFS_EN_THR |=>
      st_ff.en_thr == ($past(avs_req.writedata[7:0]) & THR_VARIANT))
      else $error("enable three write not stored");

   // A clear in the same cycle as an event must not win.
   a_flag_write: assert property (
      wr_lane && avs_req.address == OFS_FLAGS_TWO |=>
      st_ff.flags_two ==
      (($past(avs_req.writedata[7:0]) & TWO_IMPL) | $past(evt_two)))
      else $error("flag two write wrong");

   a_ctrl_bits: assert property (
      (st_ff.control & ~CTRL_MASK) == 8'h00)
      else $error("control spare bit set");

   a_prio_passes: assert property (
      (|pend) && priority_scheme_en |-> periph_irq)
      else $error("request blocked in priority mode");

   a_irq_idle: assert property (
      pend == 8'h00 |-> !periph_irq)
      else $error("request without pending source");

   // Upper lanes carry nothing; software may read full words.
   a_rdata_upper: assert property (
      avs_readdata[31:8] == 24'h00_0000)
      else $error("upper read lanes not zero");

endmodule : peripheral_irq_flag_enable_bank

/* irq_bank_pkg.sv */
package irq_bank_pkg;

   // ---------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------
   localparam int         ADDR_W         = 5;
   localparam logic [4:0] OFS_FLAGS_TWO  = 5'h00;
   localparam logic [4:0] OFS_FLAGS_THR  = 5'h04;
   localparam logic [4:0] OFS_EN_ONE     = 5'h08;
   localparam logic [4:0] OFS_EN_TWO     = 5'h0C;
   localparam logic [4:0] OFS_EN_THR     = 5'h10;
   localparam logic [4:0] OFS_CONTROL    = 5'h14;

   // ---------------------------------------------------------
   // Field layout and reset values
   // ---------------------------------------------------------
   localparam int         CTRL_PRIO_BIT  = 7;
   localparam int         CTRL_GLOB_BIT  = 6;
   localparam logic [7:0] CTRL_MASK      = 8'hC0;
   localparam logic [7:0] TWO_IMPL       = 8'hFB;
   localparam logic [7:0] THR_SW_BITS    = 8'hCF;
   localparam logic [7:0] SYNC_TWO_BITS  = 8'hC0;
   localparam logic [7:0] SER_TWO_BITS   = 8'h30;
   localparam logic [7:0] PARALLEL_BIT   = 8'h80;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam int         PINS_SYNC_TWO  = 100;
   localparam int         PINS_SER_TWO   = 80;
   localparam int         PINS_PARALLEL  = 100;

   // ---------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [3:0]        byteenable;
      logic [31:0]       writedata;
   } avs_req_t;

   typedef struct packed {
      logic osc_fail;
      logic comparator_change;
      logic network_module;
      logic collision_one;
      logic timer_three_overflow;
      logic capcmp_two;
      logic sync_port_two;
      logic collision_two;
      logic timer_four_match;
      logic capcmp_five;
      logic capcmp_four;
      logic capcmp_three;
   } irq_events_t;

endpackage : irq_bank_pkg

/* event_source.sv */
`timescale 1ns/100ps

module event_source (
   input  wire logic                      clk,
   input  wire irq_bank_pkg::irq_events_t fire,
   output irq_bank_pkg::irq_events_t      evt
);
   import irq_bank_pkg::*;

   irq_events_t last_ff;

   // -------------------------------------------------
   // Peripheral side: one-cycle pulses, same clock
   // -------------------------------------------------
   // A held request still gives a single pulse, as a real
   // peripheral event would.
   always_ff @(posedge clk) begin
      last_ff <= fire;
   end

   assign evt = fire & ~last_ff;

endmodule : event_source

/* tb_top.sv */
`timescale 1ns/100ps

module tb_top;
   import irq_bank_pkg::*;

   logic        clk;
   logic        rstn;
   avs_req_t    req;
   logic [31:0] rd;
   logic [31:0] rd_s;
   logic        wrq;
   irq_events_t fire;
   irq_events_t evt;
   logic [3:0]  pwm;
   logic        rx_full;
   logic        tx_empty;
   logic [7:0]  flags_one;
   logic        micro;
   logic        irq;
   logic        prio;
   logic        glob;
   logic [7:0]  q;
   logic [7:0]  qs;
   int          error_cnt;
   int          checks;

   // Flag bit hit by event i; i<6 lands in flags_three
   localparam logic [7:0] EVT_BIT [12] = '{8'h01, 8'h02, 8'h04, 8'h08,
      8'h40, 8'h80, 8'h01, 8'h02, 8'h08, 8'h20, 8'h40, 8'h80};

   // -------------------------------------------------
   // Devices: full variant and smallest variant
   // -------------------------------------------------
   peripheral_irq_flag_enable_bank #(.PIN_COUNT(100)) u_dut (
      .clk(clk), .rstn(rstn), .avs_req(req), .avs_readdata(rd),
      .avs_waitrequest(wrq), .evt(evt), .capcmp_pwm_mode(pwm),
      .serial_two_rx_full(rx_full), .serial_two_tx_empty(tx_empty),
      .periph_flags_one(flags_one), .micro_mode(micro),
      .periph_irq(irq), .priority_scheme_en(prio),
      .peripheral_global_irq_en(glob));

   peripheral_irq_flag_enable_bank #(.PIN_COUNT(64)) u_small (
      .clk(clk), .rstn(rstn), .avs_req(req), .avs_readdata(rd_s),
      .avs_waitrequest(), .evt(evt), .capcmp_pwm_mode(pwm),
      .serial_two_rx_full(rx_full), .serial_two_tx_empty(tx_empty),
      .periph_flags_one(flags_one), .micro_mode(micro),
      .periph_irq(), .priority_scheme_en(),
      .peripheral_global_irq_en());

   event_source u_src (.clk(clk), .fire(fire), .evt(evt));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // -------------------------------------------------
   // Tasks
   // -------------------------------------------------
   task automatic conclude();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Sampling right after the edge sees the pre-edge values
   task automatic bus(input logic wr_en, input logic [4:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req.read       <= ~wr_en;
      req.write      <= wr_en;
      req.address    <= a;
      req.byteenable <= 4'hF;
      req.writedata  <= {24'h0, d};
      @(posedge clk);
      while (wrq !== 1'b0) begin
         n++;
         if (n > 20) begin
            error_cnt++;
            $display("[ERR] %0t bus hang", $time);
            conclude();
         end
         @(posedge clk);
      end
      q  = rd[7:0];
      qs = rd_s[7:0];
      req.read  <= 1'b0;
      req.write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rdc

   task automatic chk_irq(input logic e);
      @(posedge clk);
      chk({7'h0, irq}, {7'h0, e});
   endtask : chk_irq

   task automatic fire_evt(input irq_events_t e);
      @(posedge clk);
      fire <= e;
      @(posedge clk);
      fire <= '0;
      repeat (3) @(posedge clk);
   endtask : fire_evt

   // -------------------------------------------------
   // Sequence
   // -------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("[ERR] %0t run timeout", $time);
      conclude();
   end

   initial begin
      rstn = 1'b0; req = '0; fire = '0; pwm = 4'h0; rx_full = 1'b0;
      tx_empty = 1'b0; flags_one = 8'h00; micro = 1'b1;
      error_cnt = 0; checks = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a <= 24; a += 4) rdc(a[4:0], 8'h00);
      wr(5'h18, 8'hFF);
      rdc(5'h18, 8'h00);
      wr(OFS_EN_ONE, 8'hFF);
      rdc(OFS_EN_ONE, 8'hFF);
      chk(qs, 8'h7F);
      wr(OFS_EN_ONE, 8'h00);
      micro <= 1'b0;
      wr(OFS_EN_ONE, 8'hFF);
      rdc(OFS_EN_ONE, 8'h7F);
      wr(OFS_EN_TWO, 8'hEF);
      rdc(OFS_EN_TWO, 8'hEB);
      wr(OFS_EN_THR, 8'hFF);
      rdc(OFS_EN_THR, 8'hFF);
      chk(qs, 8'h0F);
      // Enables stay set: flags must still set, irq held off
      for (int i = 0; i < 12; i++) begin
         fire_evt(irq_events_t'(12'h001 << i));
         rdc(OFS_FLAGS_TWO, i > 5 ? EVT_BIT[i] : 8'h00);
         rdc(OFS_FLAGS_THR, i < 6 ? EVT_BIT[i] : 8'h00);
         chk(qs, i < 4 ? EVT_BIT[i] : 8'h00);
         chk_irq(1'b0);
         wr(OFS_FLAGS_TWO, 8'h00);
         wr(OFS_FLAGS_THR, 8'h00);
      end
      pwm <= 4'hF;
      fire_evt(irq_events_t'(12'h047));
      rdc(OFS_FLAGS_TWO, 8'h00);
      rdc(OFS_FLAGS_THR, 8'h00);
      pwm <= 4'h0;
      rx_full <= 1'b1;
      tx_empty <= 1'b1;
      wr(OFS_FLAGS_THR, 8'h00);
      rdc(OFS_FLAGS_THR, 8'h30);
      chk(qs, 8'h00);
      rx_full <= 1'b0;
      rdc(OFS_FLAGS_THR, 8'h10);
      tx_empty <= 1'b0;
      rdc(OFS_FLAGS_THR, 8'h00);
      wr(OFS_EN_THR, 8'h00);
      fire_evt(irq_events_t'(12'h800));
      chk_irq(1'b0);
      wr(OFS_CONTROL, 8'h40);
      chk_irq(1'b1);
      chk({6'h0, prio, glob}, 8'h01);
      wr(OFS_CONTROL, 8'h80);
      chk_irq(1'b1);
      chk({6'h0, prio, glob}, 8'h02);
      wr(OFS_FLAGS_TWO, 8'h00);
      chk_irq(1'b0);
      flags_one <= 8'h01;
      chk_irq(1'b1);
      wr(OFS_EN_ONE, 8'h7E);
      chk_irq(1'b0);
      rdc(OFS_CONTROL, 8'h80);
      conclude();
   end

endmodule : tb_top
